// ---- design/p1m_regs.vh ----
// Functional notes
// R1 - On the address variant, pin 0 drives address bit 20 when the address enable field is 1101 to 1111 in modes 4, 5 and 6 only.
// R2 - With its timer channel not in an output setting, a pin is a general input at direction 0 and a general output at 1; address output overrides this.
// R3 - In the timer input or reset setting the pin also feeds the channel capture input whatever the general direction; address output forces capture to 0.
// R4 - With its timer channel in an output setting and no address output selected, the pin carries the timer output and its direction bit is ignored.
// R5 - On the variant without an address bus the pins offer only general I/O, timer I/O and the two interrupt inputs.
// R6 - Software using pin 6 or pin 4 as interrupt input 1 or 0 gives that pin no other function at the same time.
// R7 - Pins 7, 5, 3 and 2 forward their level to the timer as external clocks D, C, B and A.
// R8 - The second port has four I/O bits that can also be serial interface pins and interrupt input 4.
// R9 - The second port has direction, output data, pin state and open-drain control registers.
// R10 - The second port behaves the same on both variants, with one implementation.
// R11 - A pin state read returns the output latch where direction is 1 and the live pin level where it is 0.
// R12 - The output data register holds the values driven on pins that are general outputs.
// R13 - Pin levels pass a two-stage synchronizer before being read or forwarded to timer or interrupt logic.
`ifndef P1M_REGS_VH
`define P1M_REGS_VH

// ==========================================================
// Register byte addresses
`define P1M_ADDR_P1_DIR 12'h000
`define P1M_ADDR_P1_DATA 12'h004
`define P1M_ADDR_P1_STATE 12'h008
`define P1M_ADDR_P2_DIR 12'h00c
`define P1M_ADDR_P2_DATA 12'h010
`define P1M_ADDR_P2_STATE 12'h014
`define P1M_ADDR_P2_ODR 12'h018
`define P1M_ADDR_AE_CTRL 12'h01c

// ==========================================================
// Reset values
`define P1M_RST_BYTE 8'h00
`define P1M_RST_NIB 4'h0
`define P1M_RST_AE 4'h0

// ==========================================================
// Address enable thresholds per low pin, and valid operating modes
`define P1M_AE_PIN0 4'hd
`define P1M_AE_PIN1 4'he
`define P1M_AE_PIN23 4'hf
`define P1M_MODE_LO 3'h4
`define P1M_MODE_HI 3'h6

// ==========================================================
// Bit positions of the second port pins inside its byte registers, and the address enable field width
`define P1M_P2_B0 0
`define P1M_P2_B1 1
`define P1M_P2_B2 2
`define P1M_P2_B3 6
`define P1M_AE_W 4

`endif

// ---- design/p1m_sync.v ----
`default_nettype none

// ==========================================================
// Two-stage level synchronizer
module p1m_sync #(
    parameter W = 8
) (
    input wire core_clk_i,
    input wire rst_i,
    input wire [W-1:0] async_i,
    output wire [W-1:0] sync_o
);
    reg [W-1:0] meta_q;
    reg [W-1:0] sync_q;

    // First stage feeds only the second stage
    always @(posedge core_clk_i) begin
        if (rst_i) begin
            meta_q <= {W{1'b0}};
            sync_q <= {W{1'b0}};
        end else begin
            meta_q <= async_i; // [R13]
            sync_q <= meta_q; // [R13]
        end
    end

    assign sync_o = sync_q;
endmodule // p1m_sync

`default_nettype wire

// ---- design/p1m_top.v ----
`include "p1m_regs.vh"
`default_nettype none

// ==========================================================
// Pin-function multiplexer for an 8-bit port and a 4-bit port
// First port pin n timer mapping: 0..3 ch0 a..d, 4/5 ch1 a/b, 6/7 ch2 a/b
module p1m_top #(
    parameter ADDR_VARIANT = 1,
    parameter EXT_INTERRUPT_IN_4_PIN = 2
) (
    input wire core_clk_i,
    input wire rst_i,
    // APB slave
    input wire psel_i,
    input wire penable_i,
    input wire pwrite_i,
    input wire [11:0] paddr_i,
    input wire [31:0] pwdata_i,
    output wire pready_o,
    output wire pslverr_o,
    output wire [31:0] prdata_o,
    // Operating mode of the device
    input wire [2:0] op_mode_i,
    // High address bits 23..20 from the bus controller
    input wire [3:0] addr_hi_i,
    // Timer unit: per first-port pin output setting and level
    input wire [7:0] tmr_out_en_i,
    input wire [7:0] tmr_out_i,
    output wire [7:0] tmr_capture_o,
    output wire ext_timer_clock_a_o,
    output wire ext_timer_clock_b_o,
    output wire ext_timer_clock_c_o,
    output wire ext_timer_clock_d_o,
    output wire ext_interrupt_in_0_o,
    output wire ext_interrupt_in_1_o,
    output wire ext_interrupt_in_4_o,
    // Serial interface: per second-port pin drive request
    input wire [3:0] sci_out_en_i,
    input wire [3:0] sci_out_i,
    output wire [3:0] sci_in_o,
    // First port pads
    input wire [7:0] p1_pin_i,
    output wire [7:0] p1_pin_o,
    output wire [7:0] p1_pin_oe_o,
    // Second port pads
    input wire [3:0] p2_pin_i,
    output wire [3:0] p2_pin_o,
    output wire [3:0] p2_pin_oe_o
);

    // ==========================================================
    // Registers
    reg [7:0] first_port_direction_q;
    reg [7:0] first_port_out_data_q;
    reg [3:0] second_port_direction_q;
    reg [3:0] second_port_out_data_q;
    reg [3:0] second_port_open_drain_q;
    reg [3:0] address_enable_field_q;
    reg [31:0] prdata_q;
    reg [31:0] prdata_d;
    reg [7:0] p1_pin_q;
    wire [7:0] p1_pin_d;
    reg [7:0] p1_oe_q;
    wire [7:0] p1_oe_d;
    reg [3:0] p2_pin_q;
    wire [3:0] p2_pin_d;
    reg [3:0] p2_oe_q;
    wire [3:0] p2_oe_d;
    reg addr_hit_d;

    wire [7:0] p1_sync;
    wire [3:0] p2_sync;
    wire [7:0] p1_state;
    wire [3:0] p2_state;
    wire [7:0] p2_data_byte;
    wire [7:0] p2_state_byte;
    wire [7:0] p2_odr_byte;
    wire [7:0] wbyte;
    wire [3:0] wnib;
    wire setup_ph;
    wire access_ph;
    wire wr_en;
    wire mode_ok;
    wire [3:0] addr_pin_en;

    // ==========================================================
    // Pin synchronizers
    p1m_sync #(
        .W(12)
    ) p1m_sync_i (
        .core_clk_i(core_clk_i),
        .rst_i(rst_i),
        .async_i({p2_pin_i, p1_pin_i}),
        .sync_o({p2_sync, p1_sync})
    );

    // ==========================================================
    // APB decode
    assign setup_ph = psel_i & ~penable_i;
    assign access_ph = psel_i & penable_i;
    assign wr_en = access_ph & pwrite_i & addr_hit_d;
    assign wbyte = pwdata_i[7:0];
    assign wnib = {wbyte[`P1M_P2_B3], wbyte[`P1M_P2_B2], wbyte[`P1M_P2_B1],
                   wbyte[`P1M_P2_B0]};

    // Zero wait state; read data was captured in the setup cycle
    assign pready_o = access_ph;
    assign pslverr_o = access_ph & ~addr_hit_d;
    assign prdata_o = prdata_q;

    always @* begin
        addr_hit_d = 1'b1;
        if (paddr_i == `P1M_ADDR_P1_DIR) begin
            addr_hit_d = 1'b1;
        end else if (paddr_i == `P1M_ADDR_P1_DATA) begin
            addr_hit_d = 1'b1;
        end else if (paddr_i == `P1M_ADDR_P1_STATE) begin
            addr_hit_d = 1'b1;
        end else if (paddr_i == `P1M_ADDR_P2_DIR) begin
            addr_hit_d = 1'b1;
        end else if (paddr_i == `P1M_ADDR_P2_DATA) begin
            addr_hit_d = 1'b1;
        end else if (paddr_i == `P1M_ADDR_P2_STATE) begin
            addr_hit_d = 1'b1;
        end else if (paddr_i == `P1M_ADDR_P2_ODR) begin
            addr_hit_d = 1'b1;
        end else if (paddr_i == `P1M_ADDR_AE_CTRL) begin
            addr_hit_d = 1'b1;
        end else begin
            addr_hit_d = 1'b0;
        end
    end

    // Byte views of the second port, reserved bits read zero
    assign p2_data_byte = {1'b0, second_port_out_data_q[3], 3'h0,
                           second_port_out_data_q[2:0]};
    assign p2_state_byte = {1'b0, p2_state[3], 3'h0, p2_state[2:0]};
    assign p2_odr_byte = {1'b0, second_port_open_drain_q[3], 3'h0,
                          second_port_open_drain_q[2:0]};

    // Direction registers are write-only and read back as zero
    always @* begin
        prdata_d = prdata_q;
        if (setup_ph) begin
            prdata_d = 32'h0000_0000;
            if (pwrite_i) begin
                prdata_d = 32'h0000_0000;
            end else if (paddr_i == `P1M_ADDR_P1_DATA) begin
                prdata_d[7:0] = first_port_out_data_q;
            end else if (paddr_i == `P1M_ADDR_P1_STATE) begin
                prdata_d[7:0] = p1_state; // [R11]
            end else if (paddr_i == `P1M_ADDR_P2_DATA) begin
                prdata_d[7:0] = p2_data_byte;
            end else if (paddr_i == `P1M_ADDR_P2_STATE) begin
                prdata_d[7:0] = p2_state_byte; // [R11]
            end else if (paddr_i == `P1M_ADDR_P2_ODR) begin
                prdata_d[7:0] = p2_odr_byte;
            end else if (paddr_i == `P1M_ADDR_AE_CTRL) begin
                prdata_d[`P1M_AE_W-1:0] = address_enable_field_q;
            end else begin
                prdata_d = 32'h0000_0000;
            end
        end
    end

    // ==========================================================
    // Register writes
    always @(posedge core_clk_i) begin
        if (rst_i) begin
            first_port_direction_q <= `P1M_RST_BYTE;
            first_port_out_data_q <= `P1M_RST_BYTE;
            second_port_direction_q <= `P1M_RST_NIB;
            second_port_out_data_q <= `P1M_RST_NIB;
            second_port_open_drain_q <= `P1M_RST_NIB;
            address_enable_field_q <= `P1M_RST_AE;
            prdata_q <= 32'h0000_0000;
        end else begin
            prdata_q <= prdata_d;
            if (wr_en) begin
                if (paddr_i == `P1M_ADDR_P1_DIR) begin
                    first_port_direction_q <= wbyte;
                end else if (paddr_i == `P1M_ADDR_P1_DATA) begin
                    first_port_out_data_q <= wbyte; // [R12]
                end else if (paddr_i == `P1M_ADDR_P2_DIR) begin
                    second_port_direction_q <= wnib; // [R9]
                end else if (paddr_i == `P1M_ADDR_P2_DATA) begin
                    second_port_out_data_q <= wnib; // [R9] [R12]
                end else if (paddr_i == `P1M_ADDR_P2_ODR) begin
                    second_port_open_drain_q <= wnib; // [R9]
                end else if (paddr_i == `P1M_ADDR_AE_CTRL) begin
                    address_enable_field_q <= wpart_ae(pwdata_i);
                end
            end
        end
    end

    function [`P1M_AE_W-1:0] wpart_ae;
        input [31:0] d;
        begin
            wpart_ae = d[`P1M_AE_W-1:0];
        end
    endfunction

    // ==========================================================
    // Address output enables for the low four pins
    // A zero-valued variant parameter strips the address path entirely
    assign mode_ok = (op_mode_i >= `P1M_MODE_LO) && (op_mode_i <= `P1M_MODE_HI);
    assign addr_pin_en[0] = (ADDR_VARIANT != 0) && mode_ok &&
                            (address_enable_field_q >= `P1M_AE_PIN0); // [R1] [R5]
    assign addr_pin_en[1] = (ADDR_VARIANT != 0) && mode_ok &&
                            (address_enable_field_q >= `P1M_AE_PIN1); // [R5]
    assign addr_pin_en[2] = (ADDR_VARIANT != 0) && mode_ok &&
                            (address_enable_field_q == `P1M_AE_PIN23); // [R5]
    assign addr_pin_en[3] = addr_pin_en[2];

    // ==========================================================
    // First port per-pin function select
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi = gi + 1) begin : g_p1
            wire is_addr;
            wire addr_bit;
            reg lvl;
            reg drv;
            // Upper pins have no address line, so nothing selects past the top address bit
            if (gi < 4) begin : g_lo
                assign is_addr = addr_pin_en[gi];
                assign addr_bit = addr_hi_i[gi];
            end else begin : g_hi
                assign is_addr = 1'b0;
                assign addr_bit = 1'b0;
            end

            always @* begin
                if (is_addr) begin
                    lvl = addr_bit; // [R1]
                    drv = 1'b1;
                end else if (tmr_out_en_i[gi]) begin
                    lvl = tmr_out_i[gi]; // [R4]
                    drv = 1'b1;
                end else begin
                    lvl = first_port_out_data_q[gi]; // [R2] [R12]
                    drv = first_port_direction_q[gi]; // [R2]
                end
            end
            // One driver per bit keeps the pad vectors single-sourced
            assign p1_pin_d[gi] = lvl;
            assign p1_oe_d[gi] = drv;

            // Capture is fed in the input or reset setting, either direction, unless the pin outputs an address bit
            assign tmr_capture_o[gi] = p1_sync[gi] & ~tmr_out_en_i[gi] & ~is_addr; // [R3]
            assign p1_state[gi] = first_port_direction_q[gi] ?
                                  first_port_out_data_q[gi] : p1_sync[gi]; // [R11]
        end
    endgenerate

    // External clocks and interrupts see the synchronized level only
    assign ext_timer_clock_a_o = p1_sync[2]; // [R7]
    assign ext_timer_clock_b_o = p1_sync[3]; // [R7]
    assign ext_timer_clock_c_o = p1_sync[5]; // [R7]
    assign ext_timer_clock_d_o = p1_sync[7]; // [R7]
    // Exclusive use of these pins is left to software
    assign ext_interrupt_in_0_o = p1_sync[4]; // [R6] [R13]
    assign ext_interrupt_in_1_o = p1_sync[6]; // [R6] [R13]

    // ==========================================================
    // Second port, identical for both variants
    generate
        for (gi = 0; gi < 4; gi = gi + 1) begin : g_p2
            reg lvl;
            reg drv;
            always @* begin
                if (sci_out_en_i[gi]) begin
                    lvl = sci_out_i[gi]; // [R8]
                end else begin
                    lvl = second_port_out_data_q[gi]; // [R12]
                end
                // Open drain releases the pin instead of driving high
                drv = (sci_out_en_i[gi] | second_port_direction_q[gi]) &
                      ~(second_port_open_drain_q[gi] & lvl); // [R9] [R10]
            end
            assign p2_pin_d[gi] = lvl;
            assign p2_oe_d[gi] = drv;
            assign p2_state[gi] = second_port_direction_q[gi] ?
                                  second_port_out_data_q[gi] : p2_sync[gi]; // [R11]
        end
    endgenerate

    assign sci_in_o = p2_sync; // [R8]
    assign ext_interrupt_in_4_o = p2_sync[EXT_INTERRUPT_IN_4_PIN]; // [R8]

    // ==========================================================
    // Registered pad drive
    always @(posedge core_clk_i) begin
        if (rst_i) begin
            p1_pin_q <= `P1M_RST_BYTE;
            p1_oe_q <= `P1M_RST_BYTE;
            p2_pin_q <= `P1M_RST_NIB;
            p2_oe_q <= `P1M_RST_NIB;
        end else begin
            p1_pin_q <= p1_pin_d;
            p1_oe_q <= p1_oe_d;
            p2_pin_q <= p2_pin_d;
            p2_oe_q <= p2_oe_d;
        end
    end

    assign p1_pin_o = p1_pin_q;
    assign p1_pin_oe_o = p1_oe_q;
    assign p2_pin_o = p2_pin_q;
    assign p2_pin_oe_o = p2_oe_q;

endmodule // p1m_top

`default_nettype wire

// ---- dv/p1m_props.sv ----
`default_nettype none
// ==========================================================
// Port checker
module p1m_props #(
    parameter int ADDR_VARIANT = 1,
    parameter int EXT_INTERRUPT_IN_4_PIN = 2
) (
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic pready_o,
    input wire logic pslverr_o,
    input wire logic [2:0] op_mode_i,
    input wire logic [3:0] addr_hi_i,
    input wire logic [7:0] tmr_out_en_i,
    input wire logic [7:0] tmr_out_i,
    input wire logic [7:0] tmr_capture_o,
    input wire logic ext_timer_clock_a_o,
    input wire logic ext_timer_clock_b_o,
    input wire logic ext_timer_clock_c_o,
    input wire logic ext_timer_clock_d_o,
    input wire logic ext_interrupt_in_0_o,
    input wire logic ext_interrupt_in_1_o,
    input wire logic ext_interrupt_in_4_o,
    input wire logic [7:0] p1_pin_i,
    input wire logic [7:0] p1_pin_o,
    input wire logic [7:0] p1_pin_oe_o,
    input wire logic [3:0] p2_pin_i,
    input wire logic [3:0] sci_in_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] dir_q;
    logic [3:0] ae_q;
    logic [1:0] up_q;
    logic wr;
    logic mode_ok;
    assign wr = psel_i && penable_i && pwrite_i;
    assign mode_ok = op_mode_i >= 3'h4 && op_mode_i <= 3'h6;
    // Shadow of the direction and address enable controls; up_q hides the synchronizer fill after reset
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            dir_q <= 8'h00;
            ae_q <= 4'h0;
            up_q <= 2'h0;
        end else begin
            up_q <= up_q | {up_q[0], 1'b1};
            if (wr && paddr_i == 12'h000) begin
                dir_q <= pwdata_i[7:0];
            end
            if (wr && paddr_i == 12'h01c) begin
                ae_q <= pwdata_i[3:0];
            end
        end
    end
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (rst_i);
    a_apb_zero_wait: assert property (psel_i && penable_i |-> pready_o)
        else $error("pready low in access phase");
    a_unmapped_err: assert property (psel_i && penable_i && paddr_i[1:0] == 2'b00
        |-> pslverr_o == (paddr_i > 12'h01c)) else $error("pslverr wrong");
    a_addr_bit20: assert property (ADDR_VARIANT != 0 && mode_ok && ae_q >= 4'hd
        |=> p1_pin_oe_o[0] && p1_pin_o[0] == $past(addr_hi_i[0]))
        else $error("pin 0 not carrying address bit 20");
    a_no_addr_out: assert property (ADDR_VARIANT == 0 && !tmr_out_en_i[0]
        |=> p1_pin_oe_o[0] == $past(dir_q[0])) else $error("pin 0 drive without address bus");
    a_gpio_dir: assert property (!tmr_out_en_i[5] |=> p1_pin_oe_o[5] == $past(dir_q[5]))
        else $error("pin 5 drive does not follow direction");
    a_timer_wins: assert property (tmr_out_en_i[3] && !mode_ok
        |=> p1_pin_oe_o[3] && p1_pin_o[3] == $past(tmr_out_i[3]))
        else $error("pin 3 not carrying timer output");
    a_capture_feed: assert property (up_q[1] && !tmr_out_en_i[5]
        |-> tmr_capture_o[5] == $past(p1_pin_i[5], 2)) else $error("capture level wrong");
    a_clock_map: assert property (up_q[1] |->
        {ext_timer_clock_d_o, ext_timer_clock_c_o, ext_timer_clock_b_o, ext_timer_clock_a_o}
        == $past({p1_pin_i[7], p1_pin_i[5], p1_pin_i[3], p1_pin_i[2]}, 2))
        else $error("external timer clock mapping wrong");
    a_irq_sync: assert property (up_q[1] |-> {ext_interrupt_in_1_o, ext_interrupt_in_0_o}
        == $past({p1_pin_i[6], p1_pin_i[4]}, 2)) else $error("interrupt input level wrong");
    a_port2_sync: assert property (up_q[1] |-> sci_in_o == $past(p2_pin_i, 2)
        && ext_interrupt_in_4_o == $past(p2_pin_i[EXT_INTERRUPT_IN_4_PIN], 2))
        else $error("second port input level wrong");
    c_addr_mode: cover property (ae_q >= 4'hd && mode_ok);
    c_unmapped: cover property (psel_i && penable_i && pslverr_o);
    c_timer_out: cover property (tmr_out_en_i[3]);
endmodule // p1m_props

bind p1m_top p1m_props #(.ADDR_VARIANT(ADDR_VARIANT), .EXT_INTERRUPT_IN_4_PIN(EXT_INTERRUPT_IN_4_PIN)) p1m_props_i (
    .core_clk_i(core_clk_i), .rst_i(rst_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pready_o(pready_o),
    .pslverr_o(pslverr_o), .op_mode_i(op_mode_i), .addr_hi_i(addr_hi_i),
    .tmr_out_en_i(tmr_out_en_i), .tmr_out_i(tmr_out_i), .tmr_capture_o(tmr_capture_o),
    .ext_timer_clock_a_o(ext_timer_clock_a_o), .ext_timer_clock_b_o(ext_timer_clock_b_o),
    .ext_timer_clock_c_o(ext_timer_clock_c_o), .ext_timer_clock_d_o(ext_timer_clock_d_o),
    .ext_interrupt_in_0_o(ext_interrupt_in_0_o), .ext_interrupt_in_1_o(ext_interrupt_in_1_o),
    .ext_interrupt_in_4_o(ext_interrupt_in_4_o), .p1_pin_i(p1_pin_i), .p1_pin_o(p1_pin_o),
    .p1_pin_oe_o(p1_pin_oe_o), .p2_pin_i(p2_pin_i), .sci_in_o(sci_in_o));
`default_nettype wire

// ---- dv/tb_p1m_top.sv ----
`default_nettype none
module tb_p1m_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk_i = 1'b0, rst_i = 1'b1, psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
    logic [11:0] paddr_i = 12'h000;
    logic [31:0] pwdata_i = 32'h0, rd;
    logic [2:0] op_mode_i = 3'h0;
    logic [3:0] addr_hi_i = 4'h0, sci_out_en_i = 4'h0, sci_out_i = 4'h0, p2_ext = 4'h0;
    logic [7:0] tmr_out_en_i = 8'h00, tmr_out_i = 8'h00, p1_ext = 8'h00;
    logic er;
    wire pready_o, pslverr_o, tca, tcb, tcc, tcd, ext_interrupt_in_0, ext_interrupt_in_1, ext_interrupt_in_4;
    wire [31:0] prdata_o;
    wire [7:0] tmr_capture_o, p1_pin_o, p1_pin_oe_o, nv_oe;
    wire [3:0] sci_in_o, p2_pin_o, p2_pin_oe_o, nv_p2oe;
    // Pad level: the device wins where it drives, otherwise the outside level
    wire [7:0] p1_pin_i = (p1_pin_oe_o & p1_pin_o) | (~p1_pin_oe_o & p1_ext);
    wire [3:0] p2_pin_i = (p2_pin_oe_o & p2_pin_o) | (~p2_pin_oe_o & p2_ext);
    int error_cnt = 0, n_compared = 0, cycles = 0;
    p1m_top #(.ADDR_VARIANT(1), .EXT_INTERRUPT_IN_4_PIN(2)) p1m_top_i (
        .core_clk_i(core_clk_i), .rst_i(rst_i), .psel_i(psel_i), .penable_i(penable_i),
        .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pready_o(pready_o),
        .pslverr_o(pslverr_o), .prdata_o(prdata_o), .op_mode_i(op_mode_i),
        .addr_hi_i(addr_hi_i), .tmr_out_en_i(tmr_out_en_i), .tmr_out_i(tmr_out_i),
        .tmr_capture_o(tmr_capture_o), .ext_timer_clock_a_o(tca), .ext_timer_clock_b_o(tcb),
        .ext_timer_clock_c_o(tcc), .ext_timer_clock_d_o(tcd), .ext_interrupt_in_0_o(ext_interrupt_in_0),
        .ext_interrupt_in_1_o(ext_interrupt_in_1), .ext_interrupt_in_4_o(ext_interrupt_in_4), .sci_out_en_i(sci_out_en_i),
        .sci_out_i(sci_out_i), .sci_in_o(sci_in_o), .p1_pin_i(p1_pin_i), .p1_pin_o(p1_pin_o),
        .p1_pin_oe_o(p1_pin_oe_o), .p2_pin_i(p2_pin_i), .p2_pin_o(p2_pin_o),
        .p2_pin_oe_o(p2_pin_oe_o));
    // Variant without address bus, sharing every input
    p1m_top #(.ADDR_VARIANT(0), .EXT_INTERRUPT_IN_4_PIN(2)) p1m_top_nv_i (
        .core_clk_i(core_clk_i), .rst_i(rst_i), .psel_i(psel_i), .penable_i(penable_i),
        .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pready_o(),
        .pslverr_o(), .prdata_o(), .op_mode_i(op_mode_i), .addr_hi_i(addr_hi_i),
        .tmr_out_en_i(tmr_out_en_i), .tmr_out_i(tmr_out_i), .tmr_capture_o(),
        .ext_timer_clock_a_o(), .ext_timer_clock_b_o(), .ext_timer_clock_c_o(),
        .ext_timer_clock_d_o(), .ext_interrupt_in_0_o(), .ext_interrupt_in_1_o(),
        .ext_interrupt_in_4_o(), .sci_out_en_i(sci_out_en_i), .sci_out_i(sci_out_i),
        .sci_in_o(), .p1_pin_i(p1_pin_i), .p1_pin_o(), .p1_pin_oe_o(nv_oe),
        .p2_pin_i(p2_pin_i), .p2_pin_o(), .p2_pin_oe_o(nv_p2oe));
    // ==========================================================
    // Clock, watchdog and helpers
    always #5 core_clk_i = ~core_clk_i;
    always @(posedge core_clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            error_cnt++;
            tally_and_finish();
        end
    end
    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk_i);
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Entered just after an edge; leaves one idle cycle so psel is never driven twice at once
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel_i <= 1'b1;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge core_clk_i);
        penable_i <= 1'b1;
        // Only the bench watchdog ends a wait that never gets an answer
        do begin
            @(posedge core_clk_i);
        end while (pready_o !== 1'b1);
        rd = prdata_o;
        er = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
        @(posedge core_clk_i);
    endtask
    // ==========================================================
    // Scenarios
    task automatic t_regs();
        apb(1'b0, 12'h004, 32'h0);
        chk(rd, 32'h0);
        apb(1'b1, 12'h004, 32'hffff_ffa5);
        apb(1'b0, 12'h004, 32'h0);
        chk(rd, 32'ha5);
        apb(1'b1, 12'h010, 32'hff);
        apb(1'b0, 12'h010, 32'h0);
        chk(rd, 32'h47);
        apb(1'b1, 12'h018, 32'hff);
        apb(1'b0, 12'h018, 32'h0);
        chk(rd, 32'h47);
        apb(1'b1, 12'h000, 32'ha0);
        apb(1'b0, 12'h000, 32'h0);
        chk(rd, 32'h0);
        apb(1'b1, 12'h020, 32'hff);
        chk({31'h0, er}, 32'h1);
        apb(1'b0, 12'h020, 32'h0);
        chk({er, rd[30:0]}, 32'h8000_0000);
    endtask
    task automatic t_gpio();
        // Pins 6 and 4 stay inputs so the interrupt lines have no other function
        p1_ext <= 8'h5c;
        apb(1'b1, 12'h008, 32'h0);
        chk(p1_pin_oe_o, 8'ha0);
        chk(p1_pin_o & 8'hf0, 8'ha0);
        apb(1'b0, 12'h008, 32'h0);
        chk(rd, 32'hfc);
        chk(tmr_capture_o, 8'hfc);
        chk({tcd, tcc, tcb, tca}, 4'hf);
        chk({ext_interrupt_in_1, ext_interrupt_in_0}, 2'b11);
    endtask
    task automatic t_timer();
        tmr_out_en_i <= 8'h0f;
        tmr_out_i <= 8'h0a;
        cyc(2);
        chk(p1_pin_oe_o, 8'haf);
        chk(p1_pin_o, 8'haa);
        chk(tmr_capture_o, 8'hf0);
        tmr_out_en_i <= 8'h00;
    endtask
    task automatic t_addr();
        logic act;
        logic mok;
        addr_hi_i <= 4'h5;
        for (int m = 3; m <= 7; m++) begin
            for (int ae = 12; ae <= 15; ae++) begin
                op_mode_i <= m[2:0];
                apb(1'b1, 12'h01c, ae);
                cyc(1);
                mok = m >= 4 && m <= 6;
                act = mok && ae >= 13;
                chk(p1_pin_oe_o[0], act);
                chk(p1_pin_oe_o[3:1], {3{mok}} & {ae == 15, ae == 15, ae >= 14});
                chk(nv_oe[0], 1'b0);
                if (act) chk(p1_pin_o[0], 1'b1);
            end
        end
        apb(1'b1, 12'h01c, 32'h0);
    endtask
    task automatic t_port2();
        apb(1'b1, 12'h018, 32'h0);
        apb(1'b1, 12'h010, 32'h45);
        apb(1'b1, 12'h00c, 32'h03);
        p2_ext <= 4'ha;
        cyc(3);
        chk(p2_pin_oe_o, 4'h3);
        chk(p2_pin_o & 4'h3, 4'h1);
        chk(nv_p2oe, 4'h3);
        chk({ext_interrupt_in_4, sci_in_o}, 5'h09);
        apb(1'b0, 12'h014, 32'h0);
        chk(rd, 32'h41);
        apb(1'b1, 12'h018, 32'h01);
        sci_out_en_i <= 4'h8;
        sci_out_i <= 4'h8;
        p2_ext <= 4'h4;
        // The serial drive reaches the pad one edge later, then two more to sync
        cyc(4);
        chk(p2_pin_oe_o, 4'ha);
        chk(p2_pin_o[3], 1'b1);
        chk({ext_interrupt_in_4, sci_in_o}, 5'h1c);
    endtask
    task automatic tally_and_finish();
        $display("mismatches=%0d compared=%0d", error_cnt, n_compared);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    initial begin
        cyc(3);
        rst_i <= 1'b0;
        cyc(1);
        t_regs();
        t_gpio();
        t_timer();
        t_addr();
        t_port2();
        tally_and_finish();
    end
endmodule // tb_p1m_top
`default_nettype wire
